// file: design/charger_params.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

// ==========================================================
// Register indices and byte addresses
// ==========================================================
`define IDX_CTRL_ONE     16'h4048
`define IDX_CTRL_TWO     16'h4049
`define IDX_STATUS       16'h404A
`define IDX_EVENTS       16'h4012
`define IDX_SECURITY     16'h4008
`define ADDR_W           18
`define ADDR_OF(i)       ({2'h0, (i)} << 2)

// ==========================================================
// Field positions
// ==========================================================
`define BIT_MON_ENABLE   2
`define TSEL_LSB         8
`define TSEL_MSB         11
`define BIT_OV_FLAG      15
`define STATE_LSB        12
`define STATE_MSB        14
`define BIT_HOT_FLAG     11
`define BIT_COLD_FLAG    10
`define EV_HOT           15
`define EV_COLD          14
`define EV_FAIL          13
`define EV_OV            12

// ==========================================================
// Reset values
// ==========================================================
`define RST_MON_ENABLE   1'h0
`define RST_TSEL         4'h6
`define RST_KEY          16'h00A5

// ==========================================================
// Timing
// ==========================================================
`define CLK_HZ           20000000
`define TICK_MS          1000
`define TICK_CYCLES      ((`CLK_HZ / 1000) * `TICK_MS)
`define TIMEOUT_BASE_MIN 60
`define TIMEOUT_STEP_MIN 30
`define SEC_PER_MIN      60
`define DEFECT_TIMEOUT_S 1800
`define MON_RATIO        12500
`define NA_PER_UA        1000

`endif

// file: design/charger_pkg.sv
// Types shared by the charger supervisor.
package charger_pkg;

  // ==========================================================
  // Charge mode states
  // ==========================================================
  typedef enum logic [2:0] {
    ST_OFF,
    ST_TRICKLE,
    ST_FAST,
    ST_TRICKLE_HOLD,
    ST_FAST_HOLD,
    ST_DEFECTIVE,
    ST_TERMINATED
  } state_type;

  typedef logic [2:0] mode_code_type;

endpackage

// file: design/charger_fault_temp_supervisor.sv
// Battery charger fault and temperature supervisor with Avalon-MM registers.
//
// Overview of operation
// - Monitor enable set drives a charge-proportional current; clear drives none.
// - Monitor current equals charge current divided by 12500.
// - Monitor enable is bit 2 of control one, reset value 0.
// - Monitor enable writes are ignored unless the user key unlocked registers.
// - Overvoltage flag is read-only bit 15 of status, reset 0.
// - Overvoltage terminates charging and sets the overvoltage event flag.
// - Defective if fast threshold not reached within longer of two timeouts.
// - Failure clears on voltage above defective threshold or power reconnect.
// - After failure clears the charger returns to off and may restart.
// - Failure in fast charge drops to trickle; persisting failure stops it.
// - Battery failure terminates charging and sets the fail event flag.
// - Hot and cold flags are read-only status bits 11 and 10.
// - Hot or cold pauses charging and sets the matching event flag.
// - An unconnected thermistor suppresses spurious hot or cold indications.
// - Battery removal sensed during charging terminates charging unless the thermistor is open or strap-disabled.
// - Thermistor-disable strap is sampled only at start-up, never later.
// - Event flags set on condition rising edge, cleared by writing one.
// - Safety timer holds its count while paused and resumes afterwards.
// - Timeout select gives 60 to 510 minutes in 30-minute steps.
//
// Decided for this implementation: the Avalon-MM register port.
`include "charger_params.svh"
`timescale 1ns/1ps
`default_nettype none

module charger_fault_temp_supervisor #(
  parameter int          TICK_CYCLES      = `TICK_CYCLES,
  parameter int          DEFECT_TIMEOUT_S = `DEFECT_TIMEOUT_S,
  parameter logic [15:0] USER_KEY         = `RST_KEY, // Arbitrary value.
  parameter int          MON_RATIO        = `MON_RATIO
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic [`ADDR_W-1:0]   ADDRESS,
  input  wire logic                 READ,
  input  wire logic                 WRITE,
  input  wire logic [3:0]           BYTEENABLE,
  input  wire logic [31:0]          WRITEDATA,
  output logic      [31:0]          READDATA,
  output logic                      WAITREQUEST,
  input  wire logic                 CHARGE_REQUEST,
  input  wire logic [19:0]          CHARGE_CURRENT_UA,
  input  wire logic                 BATT_OVERVOLTAGE,
  input  wire logic                 BATT_BELOW_FAST,
  input  wire logic                 BATT_ABOVE_DEFECT,
  input  wire logic                 POWER_RECONNECT,
  input  wire logic                 THERM_HOT,
  input  wire logic                 THERM_COLD,
  input  wire logic                 THERM_OPEN,
  input  wire logic                 BATT_REMOVED,
  input  wire logic                 THERM_DISABLE_STRAP,
  output logic      [19:0]          MONITOR_CURRENT_NA,
  output logic                      CHARGE_ON,
  output logic                      FAST_MODE,
  output logic      [2:0]           CHARGE_STATE
);

  // ==========================================================
  // Avalon-MM slave decode
  // ==========================================================
  localparam logic [`ADDR_W-1:0] A_CTRL1 = `ADDR_OF(`IDX_CTRL_ONE);
  localparam logic [`ADDR_W-1:0] A_CTRL2 = `ADDR_OF(`IDX_CTRL_TWO);
  localparam logic [`ADDR_W-1:0] A_STAT  = `ADDR_OF(`IDX_STATUS);
  localparam logic [`ADDR_W-1:0] A_EVT   = `ADDR_OF(`IDX_EVENTS);
  localparam logic [`ADDR_W-1:0] A_SEC   = `ADDR_OF(`IDX_SECURITY);

  logic        wait_q;
  logic [31:0] rdata_q;
  logic        unlock_q;
  logic        mon_en_q;
  logic [3:0]  tsel_q;
  logic [15:0] evt_q;
  logic [15:0] evt_d;
  logic [19:0] mon_q;
  logic        strap_taken_q;
  logic        temp_off_q;
  logic [2:0]  mode_code;
  logic        hot_q;
  logic        cold_q;
  logic        ov_q;
  logic        fail_q;
  logic [15:0] timer_q;
  logic [31:0] tick_cnt_q;
  charger_pkg::state_type state_q;
  charger_pkg::state_type state_d;

  // The write is committed only at the edge where waitrequest is low.
  wire        req      = READ | WRITE;
  wire        commit_w = WRITE & ~wait_q;
  wire [15:0] wmask    = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
  wire [15:0] wdata    = WRITEDATA[15:0] & wmask;
  wire        hit_c1   = ADDRESS == A_CTRL1;
  wire        hit_c2   = ADDRESS == A_CTRL2;
  wire        hit_st   = ADDRESS == A_STAT;
  wire        hit_ev   = ADDRESS == A_EVT;
  wire        hit_sec  = ADDRESS == A_SEC;
  wire        wr_c1    = commit_w & hit_c1 & unlock_q & BYTEENABLE[0];
  wire        wr_c2    = commit_w & hit_c2 & unlock_q & BYTEENABLE[1];
  wire        wr_ev    = commit_w & hit_ev;
  wire        wr_sec   = commit_w & hit_sec & (&BYTEENABLE[1:0]);

  // ==========================================================
  // Live conditions
  // ==========================================================
  // Temperature faults are masked by an open thermistor or the strap.
  wire temp_live = ~temp_off_q & ~THERM_OPEN;
  wire hot_w     = THERM_HOT & temp_live;
  wire cold_w    = THERM_COLD & temp_live;
  wire temp_hold = hot_w | cold_w;
  wire removed_w = BATT_REMOVED & temp_live;

  // Register images; unmapped bits and addresses read as zero.
  wire [15:0] ctrl1_img = 16'(mon_en_q) << `BIT_MON_ENABLE;
  wire [15:0] ctrl2_img = 16'(tsel_q) << `TSEL_LSB;
  wire [15:0] stat_img  = (16'(ov_q) << `BIT_OV_FLAG)
                        | (16'(mode_code) << `STATE_LSB)
                        | (16'(hot_q) << `BIT_HOT_FLAG)
                        | (16'(cold_q) << `BIT_COLD_FLAG);
  wire [15:0] rd_img    = hit_c1 ? ctrl1_img :
                          hit_c2 ? ctrl2_img :
                          hit_st ? stat_img  :
                          hit_ev ? evt_q     :
                          16'h0000;

  // ==========================================================
  // Failure timeout
  // ==========================================================
  // Quarter of the selected charge timeout in seconds.
  wire [15:0] tsel_min  = 16'(`TIMEOUT_BASE_MIN)
                        + 16'(tsel_q) * 16'(`TIMEOUT_STEP_MIN);
  wire [15:0] quarter_s = 16'((32'(tsel_min) * `SEC_PER_MIN) / 4);
  wire [15:0] defect_s  = 16'(DEFECT_TIMEOUT_S);
  wire [15:0] limit_s   = (quarter_s > defect_s) ? quarter_s
                                                 : defect_s;
  wire        tick      = tick_cnt_q == 32'(TICK_CYCLES - 1);
  wire        running   = (state_q == charger_pkg::ST_TRICKLE)
                        | (state_q == charger_pkg::ST_FAST);
  wire        fail_hit  = running & BATT_BELOW_FAST
                        & (timer_q >= limit_s);
  wire        mode_chg  = state_d != state_q;

  // Mode code as shown in the status word.
  always_comb begin
    case (state_q)
      charger_pkg::ST_TRICKLE:      mode_code = 3'h1;
      charger_pkg::ST_FAST:         mode_code = 3'h2;
      charger_pkg::ST_TRICKLE_HOLD: mode_code = 3'h3;
      charger_pkg::ST_FAST_HOLD:    mode_code = 3'h4;
      charger_pkg::ST_DEFECTIVE:    mode_code = 3'h5;
      default:                      mode_code = 3'h0;
    endcase
  end

  // ==========================================================
  // Charge mode sequencing
  // ==========================================================
  // Terminating faults outrank pauses, which outrank progress.
  always_comb begin
    state_d = state_q;
    case (state_q)
      charger_pkg::ST_OFF: begin
        if (CHARGE_REQUEST & ~BATT_OVERVOLTAGE & ~removed_w) begin
          state_d = charger_pkg::ST_TRICKLE;
        end
      end
      charger_pkg::ST_TRICKLE, charger_pkg::ST_FAST: begin
        if (BATT_OVERVOLTAGE | removed_w) begin
          state_d = charger_pkg::ST_TERMINATED;
        end else if (fail_hit) begin
          // A fast-mode failure retries once in trickle.
          state_d = (state_q == charger_pkg::ST_FAST)
                  ? charger_pkg::ST_TRICKLE
                  : charger_pkg::ST_DEFECTIVE;
        end else if (temp_hold) begin
          state_d = (state_q == charger_pkg::ST_FAST)
                  ? charger_pkg::ST_FAST_HOLD
                  : charger_pkg::ST_TRICKLE_HOLD;
        end else if (~CHARGE_REQUEST) begin
          state_d = charger_pkg::ST_OFF;
        end else if (state_q == charger_pkg::ST_TRICKLE & ~BATT_BELOW_FAST) begin
          state_d = charger_pkg::ST_FAST;
        end
      end
      charger_pkg::ST_TRICKLE_HOLD, charger_pkg::ST_FAST_HOLD: begin
        if (BATT_OVERVOLTAGE | removed_w) begin
          state_d = charger_pkg::ST_TERMINATED;
        end else if (~CHARGE_REQUEST) begin
          state_d = charger_pkg::ST_OFF;
        end else if (~temp_hold) begin
          state_d = (state_q == charger_pkg::ST_FAST_HOLD)
                  ? charger_pkg::ST_FAST
                  : charger_pkg::ST_TRICKLE;
        end
      end
      charger_pkg::ST_DEFECTIVE: begin
        if (BATT_ABOVE_DEFECT | POWER_RECONNECT) begin
          state_d = charger_pkg::ST_OFF;
        end
      end
      charger_pkg::ST_TERMINATED: begin
        // Stays off until the charge request is withdrawn.
        if (~CHARGE_REQUEST) begin
          state_d = charger_pkg::ST_OFF;
        end
      end
      default: state_d = charger_pkg::ST_OFF;
    endcase
  end

  // ==========================================================
  // Event flags
  // ==========================================================
  // A new edge in the clearing cycle wins, so no event is lost.
  always_comb begin
    evt_d = evt_q;
    if (wr_ev) begin
      evt_d = evt_q & ~wdata;
    end
    if (hot_w & ~hot_q) begin
      evt_d[`EV_HOT] = 1'b1;
    end
    if (cold_w & ~cold_q) begin
      evt_d[`EV_COLD] = 1'b1;
    end
    if (fail_hit & ~fail_q) begin
      evt_d[`EV_FAIL] = 1'b1;
    end
    if (BATT_OVERVOLTAGE & ~ov_q) begin
      evt_d[`EV_OV] = 1'b1;
    end
    evt_d[11:0] = 12'h000;
  end

  // ==========================================================
  // Bus response
  // ==========================================================
  // One wait cycle per access; read data is loaded with the answer.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q  <= ~(req & wait_q);
      rdata_q <= (READ & wait_q) ? {16'h0000, rd_img} : rdata_q;
    end
  end

  // ==========================================================
  // Software registers
  // ==========================================================
  // Any security write with both low bytes enabled, other than the key, locks the registers again.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      unlock_q <= 1'b0;
      mon_en_q <= `RST_MON_ENABLE;
      tsel_q   <= `RST_TSEL;
      evt_q    <= 16'h0000;
    end else begin
      if (wr_sec) begin
        unlock_q <= wdata == USER_KEY;
      end
      if (wr_c1) begin
        mon_en_q <= wdata[`BIT_MON_ENABLE];
      end
      if (wr_c2) begin
        tsel_q <= wdata[`TSEL_MSB:`TSEL_LSB];
      end
      evt_q <= evt_d;
    end
  end

  // ==========================================================
  // Start-up strap and live status
  // ==========================================================
  // The strap is caught once after reset release and then frozen.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      strap_taken_q <= 1'b0;
      temp_off_q    <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      temp_off_q    <= THERM_DISABLE_STRAP;
    end
  end

  // Status bits track the live levels; software cannot write them.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ov_q   <= 1'b0;
      hot_q  <= 1'b0;
      cold_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      ov_q   <= BATT_OVERVOLTAGE;
      hot_q  <= hot_w;
      cold_q <= cold_w;
      fail_q <= fail_hit;
    end
  end

  // ==========================================================
  // Safety timer
  // ==========================================================
  // Entering trickle or fast other than from a pause restarts the count; pause states keep it.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tick_cnt_q <= 32'h0000_0000;
      timer_q    <= 16'h0000;
    end else if (mode_chg & (state_d == charger_pkg::ST_TRICKLE
                 | state_d == charger_pkg::ST_FAST)
                 & ~(state_q == charger_pkg::ST_TRICKLE_HOLD
                 | state_q == charger_pkg::ST_FAST_HOLD)) begin
      tick_cnt_q <= 32'h0000_0000;
      timer_q    <= 16'h0000;
    end else if (running) begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      if (tick & (timer_q != 16'hFFFF)) begin
        timer_q <= timer_q + 16'h0001;
      end
    end
  end

  // Held states fall through and leave both counters alone.

  // ==========================================================
  // Mode state and monitor current
  // ==========================================================
  // The monitor value is a digital scale of the charge current.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= charger_pkg::ST_OFF;
      mon_q   <= 20'h00000;
    end else begin
      state_q <= state_d;
      if (mon_en_q) begin
        mon_q <= 20'((40'(CHARGE_CURRENT_UA) * `NA_PER_UA)
                 / MON_RATIO);
      end else begin
        mon_q <= 20'h00000;
      end
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Every output below is a flip-flop or a fixed function of state_q.
  logic       on_q;
  logic       fast_q;
  logic [2:0] code_q;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      on_q   <= 1'b0;
      fast_q <= 1'b0;
      code_q <= 3'h0;
    end else begin
      on_q   <= (state_d == charger_pkg::ST_TRICKLE)
              | (state_d == charger_pkg::ST_FAST);
      fast_q <= state_d == charger_pkg::ST_FAST;
      code_q <= mode_code;
    end
  end

  assign READDATA           = rdata_q;
  assign WAITREQUEST        = wait_q;
  assign MONITOR_CURRENT_NA = mon_q;
  assign CHARGE_ON          = on_q;
  assign FAST_MODE          = fast_q;
  assign CHARGE_STATE       = code_q;

endmodule

`default_nettype wire

// file: bench/battery_pack_model.sv
// Behavioural battery pack with thermistor, driving the supervisor's sense inputs.
`timescale 1ns/1ps
`default_nettype none

module battery_pack_model (
  input  wire logic        clk,
  input  wire logic [6:0]  cond_set,
  input  wire logic [19:0] amps_ua,
  output logic             over_volt,
  output logic             below_fast,
  output logic             above_defect,
  output logic             hot,
  output logic             cold,
  output logic             open_ntc,
  output logic             removed,
  output logic [19:0]      current_ua
);
  // ==========================================================
  // Pack state
  // ==========================================================
  logic [6:0]  cond_q = 7'h00;
  logic [19:0] amps_q = 20'h00000;

  // Conditions settle one clock after the bench asks for them.
  always_ff @(posedge clk) begin
    cond_q <= cond_set;
    amps_q <= amps_ua;
  end

  // A removed pack cannot draw current, so the sensed current drops too.
  assign {over_volt, below_fast, above_defect} = cond_q[6:4];
  assign {hot, cold, open_ntc, removed}        = cond_q[3:0];
  assign current_ua = removed ? 20'h00000 : amps_q;
endmodule

`default_nettype wire

// file: bench/charger_fault_temp_supervisor_assertions.sv
// Port-level concurrent checks for the charger supervisor.
`include "charger_params.svh"
`timescale 1ns/1ps
`default_nettype none

module supervisor_checker #(
  parameter int MON_RATIO = `MON_RATIO
) (
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic [`ADDR_W-1:0] ADDRESS,
  input wire logic               READ,
  input wire logic               WRITE,
  input wire logic [31:0]        READDATA,
  input wire logic               WAITREQUEST,
  input wire logic [19:0]        CHARGE_CURRENT_UA,
  input wire logic               BATT_OVERVOLTAGE,
  input wire logic               BATT_BELOW_FAST,
  input wire logic               THERM_HOT,
  input wire logic               THERM_OPEN,
  input wire logic               BATT_REMOVED,
  input wire logic [19:0]        MONITOR_CURRENT_NA,
  input wire logic               CHARGE_ON,
  input wire logic               FAST_MODE,
  input wire logic [2:0]         CHARGE_STATE
);
  // ==========================================================
  // Clocking and sequences
  // ==========================================================
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  // Charge output drops first, the mode code shows the hold a cycle later.
  sequence hold_seq;
    !CHARGE_ON ##1 CHARGE_STATE == 3'h4;
  endsequence

  // ==========================================================
  // Assertions
  // ==========================================================
  wait_one_a: assert property ($fell(WAITREQUEST) |=> WAITREQUEST)
    else $error("wait low longer than one cycle");
  wait_cause_a: assert property ($fell(WAITREQUEST) |-> $past(READ || WRITE))
    else $error("bus answered without a request");
  mon_ratio_a: assert property (MONITOR_CURRENT_NA != 20'h0 |->
    32'(MONITOR_CURRENT_NA) == 32'($past(CHARGE_CURRENT_UA)) * `NA_PER_UA
    / MON_RATIO) else $error("monitor current not at the ratio");
  ov_stop_a: assert property (BATT_OVERVOLTAGE && CHARGE_ON |=> !CHARGE_ON)
    else $error("overvoltage did not stop charging");
  gone_stop_a: assert property (
    BATT_REMOVED && !THERM_OPEN && CHARGE_ON |=> !CHARGE_ON)
    else $error("battery removal did not stop charging");
  hot_hold_a: assert property (FAST_MODE && THERM_HOT && !THERM_OPEN &&
    !BATT_OVERVOLTAGE && !BATT_REMOVED && !BATT_BELOW_FAST |=> hold_seq)
    else $error("hot battery did not pause fast charge");
  fast_no_defect_a: assert property (
    CHARGE_STATE == 3'h2 |=> CHARGE_STATE != 3'h5)
    else $error("fast charge went straight to defective");
  on_code_a: assert property (
    CHARGE_ON |=> CHARGE_STATE inside {3'h1, 3'h2})
    else $error("charging while mode code not charging");
  ov_read_a: assert property (READ && WAITREQUEST &&
    ADDRESS == `ADDR_OF(`IDX_STATUS) && $stable(BATT_OVERVOLTAGE) |=>
    READDATA[`BIT_OV_FLAG] == $past(BATT_OVERVOLTAGE))
    else $error("overvoltage flag does not follow its input");
endmodule

bind charger_fault_temp_supervisor supervisor_checker #(
  .MON_RATIO(MON_RATIO)
) i_supervisor_checker (.*);

`default_nettype wire

// file: bench/test_charger_fault_temp_supervisor.sv
// Self-checking testbench for the charger fault and temperature supervisor.
`include "charger_params.svh"
`timescale 1ns/1ps
`default_nettype none

module test_charger_fault_temp_supervisor;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int b_ov = 6, b_below = 5, b_above = 4, b_hot = 3;
  localparam int b_cold = 2, b_open = 1, b_gone = 0;
  logic CLK = 1'b0, RST_N = 1'b0, READ = 1'b0, WRITE = 1'b0;
  logic CHARGE_REQUEST = 1'b0, POWER_RECONNECT = 1'b0, STRAP = 1'b0;
  logic [`ADDR_W-1:0] ADDRESS = '0;
  logic [31:0] WRITEDATA = 32'h0, READDATA, rd_q;
  logic [6:0]  pack_set = 7'h00;
  logic [19:0] amps = 20'h00000, cur_s, MONITOR_CURRENT_NA;
  logic        WAITREQUEST, CHARGE_ON, FAST_MODE;
  logic        ov_s, below_s, above_s, hot_s, cold_s, open_s, gone_s;
  logic [2:0]  CHARGE_STATE;
  int          failures = 0, checked = 0;

  // Short tick and failure timeout keep the defective case brief.
  charger_fault_temp_supervisor #(.TICK_CYCLES(4), .DEFECT_TIMEOUT_S(3))
  i_charger_fault_temp_supervisor (.*, .BYTEENABLE(4'h3),
    .CHARGE_CURRENT_UA(cur_s), .BATT_OVERVOLTAGE(ov_s),
    .BATT_BELOW_FAST(below_s), .BATT_ABOVE_DEFECT(above_s),
    .THERM_HOT(hot_s), .THERM_COLD(cold_s), .THERM_OPEN(open_s),
    .BATT_REMOVED(gone_s), .THERM_DISABLE_STRAP(STRAP));

  battery_pack_model i_battery_pack_model (.clk(CLK), .cond_set(pack_set),
    .amps_ua(amps), .over_volt(ov_s), .below_fast(below_s),
    .above_defect(above_s), .hot(hot_s), .cold(cold_s), .open_ntc(open_s),
    .removed(gone_s), .current_ua(cur_s));

  // Free-running 20 MHz clock.
  initial begin
    forever #25 CLK = ~CLK;
  end

  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon access; an idle cycle follows so strobes never rise twice.
  task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    ADDRESS <= `ADDR_OF(idx);
    READ <= !w;
    WRITE <= w;
    WRITEDATA <= d;
    do begin
      @(posedge CLK);
      n++;
    end while (WAITREQUEST !== 1'b0 && n < 50);
    rd_q = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
    if (n >= 50) chk("bus answer", 32'h1, 32'h0);
    @(posedge CLK);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx,
                        input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, rd_q & m);
  endtask

  // Polls the mode code; a nonzero lo also bounds how early it may arrive.
  task automatic wait_state(input string nm, input logic [2:0] e,
                            input int lo, input int hi);
    int n;
    n = 0;
    while (CHARGE_STATE !== e && n < hi) begin
      @(posedge CLK);
      n++;
    end
    chk(nm, {29'h0, e}, {29'h0, CHARGE_STATE});
    if (lo > 0) chk({nm, " early"}, 32'h1, 32'(n >= lo));
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset;
    rd_chk("enable reset", `IDX_CTRL_ONE, 32'h4, 32'h0);
    rd_chk("tsel reset", `IDX_CTRL_TWO, 32'hF00, 32'h600);
    rd_chk("status reset", `IDX_STATUS, 32'h8C00, 32'h0);
    rd_chk("unmapped", 16'h4100, 32'hFFFFFFFF, 32'h0);
    $display("reset test done");
  endtask

  task automatic t_monitor;
    amps <= 20'hDBBA0;
    bus(1'b1, `IDX_CTRL_ONE, 32'h4);
    rd_chk("locked enable", `IDX_CTRL_ONE, 32'h4, 32'h0);
    chk("monitor idle", 32'h0, {12'h0, MONITOR_CURRENT_NA});
    bus(1'b1, `IDX_SECURITY, {16'h0, `RST_KEY});
    bus(1'b1, `IDX_CTRL_ONE, 32'h4);
    rd_chk("enable set", `IDX_CTRL_ONE, 32'h4, 32'h4);
    chk("monitor 900mA", 32'h11940, {12'h0, MONITOR_CURRENT_NA});
    amps <= 20'h030D3;
    repeat (4) @(posedge CLK);
    chk("monitor trunc", 32'h3E7, {12'h0, MONITOR_CURRENT_NA});
    bus(1'b1, `IDX_CTRL_ONE, 32'h0);
    repeat (2) @(posedge CLK);
    chk("monitor off", 32'h0, {12'h0, MONITOR_CURRENT_NA});
    $display("monitor test done");
  endtask

  task automatic t_ov;
    pack_set[b_below] <= 1'b1;
    CHARGE_REQUEST <= 1'b1;
    wait_state("trickle", 3'h1, 0, 50);
    pack_set[b_ov] <= 1'b1;
    wait_state("ov stop", 3'h0, 0, 50);
    chk("ov charge off", 32'h0, {31'h0, CHARGE_ON});
    rd_chk("ov flag", `IDX_STATUS, 32'h8000, 32'h8000);
    rd_chk("ov event", `IDX_EVENTS, 32'h1000, 32'h1000);
    bus(1'b1, `IDX_EVENTS, 32'h1000);
    rd_chk("ov event clr", `IDX_EVENTS, 32'h1000, 32'h0);
    bus(1'b1, `IDX_STATUS, 32'h0);
    rd_chk("ov flag kept", `IDX_STATUS, 32'h8000, 32'h8000);
    pack_set[b_ov] <= 1'b0;
    CHARGE_REQUEST <= 1'b0;
    repeat (3) @(posedge CLK);
    rd_chk("ov flag live", `IDX_STATUS, 32'h8000, 32'h0);
    pack_set[b_below] <= 1'b0;
    $display("overvoltage test done");
  endtask

  task automatic t_temp;
    CHARGE_REQUEST <= 1'b1;
    wait_state("fast", 3'h2, 0, 50);
    chk("fast flag", 32'h1, {31'h0, FAST_MODE});
    STRAP <= 1'b1;
    pack_set[b_hot] <= 1'b1;
    wait_state("hot hold", 3'h4, 0, 50);
    rd_chk("hot flag", `IDX_STATUS, 32'hC00, 32'h800);
    rd_chk("hot event", `IDX_EVENTS, 32'hC000, 32'h8000);
    pack_set[b_hot] <= 1'b0;
    wait_state("hot resume", 3'h2, 0, 50);
    pack_set[b_open] <= 1'b1;
    pack_set[b_cold] <= 1'b1;
    repeat (10) @(posedge CLK);
    chk("open no hold", 32'h2, {29'h0, CHARGE_STATE});
    rd_chk("open no event", `IDX_EVENTS, 32'h4000, 32'h0);
    pack_set[b_open] <= 1'b0;
    wait_state("cold hold", 3'h4, 0, 50);
    rd_chk("cold event", `IDX_EVENTS, 32'h4000, 32'h4000);
    pack_set[b_cold] <= 1'b0;
    wait_state("cold resume", 3'h2, 0, 50);
    pack_set[b_gone] <= 1'b1;
    wait_state("removed stop", 3'h0, 0, 50);
    chk("removed off", 32'h0, {31'h0, CHARGE_ON});
    pack_set[b_gone] <= 1'b0;
    CHARGE_REQUEST <= 1'b0;
    STRAP <= 1'b0;
    repeat (3) @(posedge CLK);
    $display("temperature test done");
  endtask

  // Select 0 gives 60 minutes, a quarter of which is 900 one-second ticks.
  task automatic t_fail;
    bus(1'b1, `IDX_CTRL_TWO, 32'h0);
    rd_chk("tsel zero", `IDX_CTRL_TWO, 32'hF00, 32'h0);
    pack_set[b_below] <= 1'b1;
    CHARGE_REQUEST <= 1'b1;
    wait_state("trickle start", 3'h1, 0, 50);
    wait_state("defective", 3'h5, 3500, 3800);
    chk("fail off", 32'h0, {31'h0, CHARGE_ON});
    rd_chk("fail event", `IDX_EVENTS, 32'h2000, 32'h2000);
    pack_set[b_above] <= 1'b1;
    wait_state("fail cleared", 3'h0, 0, 50);
    pack_set[b_above] <= 1'b0;
    wait_state("restart", 3'h1, 0, 50);
    CHARGE_REQUEST <= 1'b0;
    $display("failure test done");
  endtask

  // ==========================================================
  // Run control
  // ==========================================================
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog at about sixteen times the expected run.
  initial begin
    #3000000;
    failures++;
    summarize();
  end

  // Reset for eight cycles, then the scenarios in turn.
  initial begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_reset();
    t_monitor();
    t_ov();
    t_temp();
    t_fail();
    summarize();
  end
endmodule

`default_nettype wire
